// File: core/e1rs_pkg.sv
package e1rs_pkg;

    // ==========================================
    // Register map and field positions
    localparam logic [7:0] ADDR_ALARM = 8'h06;
    localparam logic [7:0] ADDR_INFO  = 8'h08;
    localparam logic [7:0] ADDR_SYNC  = 8'h1E;
    localparam logic [7:0] RESET_VIEW = 8'h00;

    localparam int BIT_SA1  = 7;
    localparam int BIT_DMA  = 6;
    localparam int BIT_SA0  = 5;
    localparam int BIT_SLIP = 4;
    localparam int BIT_UA1  = 3;
    localparam int BIT_RA   = 2;
    localparam int BIT_CL   = 1;
    localparam int BIT_LOS  = 0;

    // ==========================================
    // Stream positions
    localparam logic [4:0] SLOT_ALIGN  = 5'h00;
    localparam logic [4:0] SLOT_SIG    = 5'h10;
    localparam logic [3:0] FRAME_FIRST = 4'h0;
    localparam logic [3:0] FRAME_LAST  = 4'hF;
    localparam logic [2:0] BIT_LAST    = 3'h7;
    localparam logic [2:0] DMA_BIT_IDX = 3'h5;
    localparam logic [2:0] RA_BIT_IDX  = 3'h2;

    // ==========================================
    // Alarm thresholds and timing
    localparam int          CNT_W         = 6;
    localparam logic [1:0]  ZERO_MIN      = 2'h3;
    localparam logic [1:0]  RA_RUN        = 2'h3;
    localparam logic [8:0]  UA1_LAST      = 9'h1FF;
    localparam logic [11:0] CL_ZEROS_STD  = 12'h0FF;
    localparam logic [11:0] CL_ZEROS_EXT  = 12'h800;
    localparam logic [7:0]  CL_WIN_LAST   = 8'hFE;
    localparam logic [5:0]  CL_ONES_MIN   = 6'h20;
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          CRC_WINDOW_NS = 8000000;
    localparam int          CRC_WINDOW_CYCLES = CRC_WINDOW_NS / CLK_PERIOD_NS;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } e1rs_bus_req_type;

    typedef struct packed {
        logic       valid;
        logic       data;
        logic [4:0] slot;
        logic [2:0] bit_idx;
        logic [3:0] frame;
        logic       non_align;
    } e1rs_rx_bit_type;

endpackage

// File: core/e1rs_status.sv
// Summary of operation
// - Live register shows count bits 5..2, 0
// - Flag high while CAS multiframe search runs
// - Flag high while CRC4 multiframe search runs
// - Count up on each 8 ms timeout
// - Count cleared on CRC4 multiframe sync
// - Count held zero while CRC4 disabled
// - Count wraps from maximum to zero
// - Fewer than three zeros sets all-ones
// - All-zero signaling slot sets all-zeros
// - Signaling change sets both signaling flags
// - Alarms stay active in common-channel mode
// - Distant alarm follows two equal multiframes
// - Elastic store slip sets slip flag
// - Unframed all-ones judged per 512 bits
// - Remote alarm follows three equal occasions
// - Carrier loss after 255/2048 zeros
// - Carrier clears on 32 ones per 255
// - Four alarm changes pull interrupt low
// - Mask write refreshes only selected bits
// - Live register needs no mask write
module e1rs_status #(
    parameter int SEARCH_WINDOW_CYCLES = e1rs_pkg::CRC_WINDOW_CYCLES
) (
    input  wire  logic                       clk_sys,
    input  wire  logic                       rst_b,
    input  wire  e1rs_pkg::e1rs_bus_req_type bus_req,
    output       logic [7:0]                 bus_rdata_q,
    input  wire  e1rs_pkg::e1rs_rx_bit_type  rx_bit,
    input  wire  logic                       frame_sync,
    input  wire  logic                       cas_mf_sync,
    input  wire  logic                       crc_mf_sync,
    input  wire  logic                       crc_framing_enable,
    input  wire  logic                       carrier_loss_extended,
    input  wire  logic                       signaling_change,
    input  wire  logic                       receive_slip,
    input  wire  logic [7:0]                 info_events,
    output       logic                       int_n_q
);
    import e1rs_pkg::*;

    localparam int TMR_W = $clog2(SEARCH_WINDOW_CYCLES + 1);

    // ==========================================
    // Helpers

    // Refresh view only where the mask is set
    function automatic logic [7:0] view_upd(input logic [7:0] view,
                                            input logic [7:0] stk,
                                            input logic [7:0] set,
                                            input logic [7:0] mask);
        view_upd = (view & ~mask) | ((stk | set) & mask);
    endfunction

    // Set wins over the clear that a mask write gives
    function automatic logic [7:0] sticky_upd(input logic [7:0] stk,
                                              input logic [7:0] set,
                                              input logic [7:0] mask);
        sticky_upd = (stk & ~mask) | set;
    endfunction

    // Zero counter saturating at three
    function automatic logic [1:0] sat_zero(input logic [1:0] c,
                                            input logic       b);
        sat_zero = (b || c == ZERO_MIN) ? c : c + 2'h1;
    endfunction

    // ==========================================
    // Stream decode
    logic bit_ts16;
    logic mf_end;
    logic dma_slot;
    logic ra_slot;
    logic cas_search;
    logic crc_search;

    assign bit_ts16 = rx_bit.valid && rx_bit.slot == SLOT_SIG;
    assign mf_end   = bit_ts16 && rx_bit.frame == FRAME_LAST
                      && rx_bit.bit_idx == BIT_LAST;
    assign dma_slot = bit_ts16 && rx_bit.frame == FRAME_FIRST
                      && rx_bit.bit_idx == DMA_BIT_IDX;
    assign ra_slot  = rx_bit.valid && rx_bit.non_align
                      && rx_bit.slot == SLOT_ALIGN
                      && rx_bit.bit_idx == RA_BIT_IDX;

    // Searches only make sense once the basic frame is found
    assign cas_search = frame_sync && !cas_mf_sync;
    assign crc_search = crc_framing_enable && frame_sync && !crc_mf_sync;

    // ==========================================
    // CRC4 search window and sync counter
    logic [TMR_W-1:0] tmr_q;
    logic             tmr_expire;
    logic [CNT_W-1:0] cnt_q;

    assign tmr_expire = crc_search && tmr_q == TMR_W'(SEARCH_WINDOW_CYCLES - 1);

    // Window restarts whenever the search stops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tmr_q <= '0;
        end else if (!crc_search || tmr_expire) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= tmr_q + TMR_W'(1);
        end
    end

    // Host judges elapsed search time from this count
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (!crc_framing_enable || crc_mf_sync) begin
            cnt_q <= '0;
        end else if (tmr_expire) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ==========================================
    // Signaling slot alarms, no mode gating
    logic [1:0] sa_zero_q;
    logic       sa_one_q;
    logic       sa1_q;
    logic       sa0_q;
    logic [1:0] sa_zero_d;
    logic       sa_one_d;

    assign sa_zero_d = bit_ts16 ? sat_zero(sa_zero_q, rx_bit.data) : sa_zero_q;
    assign sa_one_d  = sa_one_q || (bit_ts16 && rx_bit.data);

    // Judged once per multiframe, counting its last bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sa_zero_q <= '0;
            sa_one_q  <= 1'b0;
            sa1_q     <= 1'b0;
            sa0_q     <= 1'b0;
        end else if (mf_end) begin
            sa1_q     <= sa_zero_d < ZERO_MIN;
            sa0_q     <= !sa_one_d;
            sa_zero_q <= '0;
            sa_one_q  <= 1'b0;
        end else begin
            sa_zero_q <= sa_zero_d;
            sa_one_q  <= sa_one_d;
        end
    end

    // ==========================================
    // Distant multiframe alarm
    logic dma_prev_q;
    logic dma_q;

    // Two equal samples in a row move the alarm
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dma_prev_q <= 1'b0;
            dma_q      <= 1'b0;
        end else if (dma_slot) begin
            dma_prev_q <= rx_bit.data;
            if (rx_bit.data == dma_prev_q) begin
                dma_q <= rx_bit.data;
            end
        end
    end

    // ==========================================
    // Unframed all-ones over 512-bit blocks
    logic [8:0] ua_pos_q;
    logic [1:0] ua_zero_q;
    logic       ua1_q;

    // Fixed blocks rather than a sliding span, to save a 512-bit history
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ua_pos_q  <= '0;
            ua_zero_q <= '0;
            ua1_q     <= 1'b0;
        end else if (rx_bit.valid) begin
            ua_pos_q <= ua_pos_q + 9'h001;
            if (ua_pos_q == UA1_LAST) begin
                ua1_q     <= sat_zero(ua_zero_q, rx_bit.data) < ZERO_MIN;
                ua_zero_q <= '0;
            end else begin
                ua_zero_q <= sat_zero(ua_zero_q, rx_bit.data);
            end
        end
    end

    // ==========================================
    // Remote alarm
    logic       ra_last_q;
    logic [1:0] ra_run_q;
    logic [1:0] ra_run_d;
    logic       ra_q;

    assign ra_run_d = (rx_bit.data != ra_last_q) ? 2'h1
                    : (ra_run_q == RA_RUN) ? ra_run_q : ra_run_q + 2'h1;

    // Run of equal values; a third one moves the alarm
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ra_last_q <= 1'b0;
            ra_run_q  <= '0;
            ra_q      <= 1'b0;
        end else if (ra_slot) begin
            ra_last_q <= rx_bit.data;
            ra_run_q  <= ra_run_d;
            if (ra_run_d == RA_RUN) begin
                ra_q <= rx_bit.data;
            end
        end
    end

    // ==========================================
    // Carrier loss
    logic [11:0] cl_run_q;
    logic [11:0] cl_run_d;
    logic [11:0] cl_thr;
    logic [7:0]  cl_win_q;
    logic [5:0]  cl_ones_q;
    logic [5:0]  cl_ones_d;
    logic        cl_set;
    logic        cl_q;

    assign cl_thr    = carrier_loss_extended ? CL_ZEROS_EXT : CL_ZEROS_STD;
    assign cl_run_d  = rx_bit.data ? 12'h000
                     : (cl_run_q == 12'hFFF) ? cl_run_q : cl_run_q + 12'h001;
    assign cl_ones_d = (rx_bit.data && cl_ones_q != CL_ONES_MIN)
                     ? cl_ones_q + 6'h01 : cl_ones_q;
    assign cl_set    = rx_bit.valid && cl_run_d >= cl_thr;

    // Set beats a clear landing on the same bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cl_run_q  <= '0;
            cl_win_q  <= '0;
            cl_ones_q <= '0;
            cl_q      <= 1'b0;
        end else if (rx_bit.valid) begin
            cl_run_q <= cl_run_d;
            if (cl_win_q == CL_WIN_LAST) begin
                cl_win_q  <= '0;
                cl_ones_q <= '0;
            end else begin
                cl_win_q  <= cl_win_q + 8'h01;
                cl_ones_q <= cl_ones_d;
            end
            if (cl_set) begin
                cl_q <= 1'b1;
            end else if (cl_win_q == CL_WIN_LAST && cl_ones_d >= CL_ONES_MIN) begin
                cl_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // Latched status registers
    logic [7:0] alm_set;
    logic [7:0] alm_mask;
    logic [7:0] info_mask;
    logic [7:0] alm_stk_q;
    logic [7:0] alm_view_q;
    logic [7:0] info_stk_q;
    logic [7:0] info_view_q;

    // Alarm levels and event pulses feeding the latches
    always_comb begin
        alm_set           = '0;
        alm_set[BIT_SA1]  = sa1_q || signaling_change;
        alm_set[BIT_DMA]  = dma_q;
        alm_set[BIT_SA0]  = sa0_q || signaling_change;
        alm_set[BIT_SLIP] = receive_slip;
        alm_set[BIT_UA1]  = ua1_q;
        alm_set[BIT_RA]   = ra_q;
        alm_set[BIT_CL]   = cl_q;
        alm_set[BIT_LOS]  = !frame_sync;
    end

    assign alm_mask  = (bus_req.wr && bus_req.addr == ADDR_ALARM) ? bus_req.wdata : 8'h00;
    assign info_mask = (bus_req.wr && bus_req.addr == ADDR_INFO) ? bus_req.wdata : 8'h00;

    // Unmasked positions keep what the host last saw
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alm_stk_q   <= RESET_VIEW;
            alm_view_q  <= RESET_VIEW;
            info_stk_q  <= RESET_VIEW;
            info_view_q <= RESET_VIEW;
        end else begin
            alm_stk_q   <= sticky_upd(alm_stk_q, alm_set, alm_mask);
            alm_view_q  <= view_upd(alm_view_q, alm_stk_q, alm_set, alm_mask);
            info_stk_q  <= sticky_upd(info_stk_q, info_events, info_mask);
            info_view_q <= view_upd(info_view_q, info_stk_q, info_events, info_mask);
        end
    end

    // ==========================================
    // Interrupt on alarm state change
    logic [3:0] live4;
    logic [3:0] prev4_q;
    logic [3:0] pend_q;
    logic [3:0] pend_d;

    assign live4  = alm_set[BIT_UA1:BIT_LOS];
    assign pend_d = (pend_q & ~alm_mask[BIT_UA1:BIT_LOS]) | (live4 ^ prev4_q);

    // Both edges of each of the four interrupting alarms (UA1, RA, CL, LOS) count as a change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prev4_q <= '0;
            pend_q  <= '0;
            int_n_q <= 1'b1;
        end else begin
            prev4_q <= live4;
            pend_q  <= pend_d;
            int_n_q <= ~|pend_d;
        end
    end

    // ==========================================
    // Read port
    logic [7:0] sync_live;

    // Count bit 1 is not visible to the host
    assign sync_live = {cnt_q[5:2], cnt_q[0], !frame_sync, cas_search, crc_search};

    // Unmapped addresses read as zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_ALARM: bus_rdata_q <= alm_view_q;
                ADDR_INFO:  bus_rdata_q <= info_view_q;
                ADDR_SYNC:  bus_rdata_q <= sync_live;
                default:    bus_rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_sync_read;
        bus_req.rd && bus_req.addr == ADDR_SYNC;
    endsequence

    sequence s_alarm_write_keep0;
        bus_req.wr && bus_req.addr == ADDR_ALARM && !bus_req.wdata[BIT_LOS];
    endsequence

    property p_sync_layout;
        s_sync_read |=> bus_rdata_q[7:3] == {$past(cnt_q[5:2]), $past(cnt_q[0])};
    endproperty
    a_sync_layout: assert property (p_sync_layout) else $error("sync count layout");

    property p_cas_flag;
        s_sync_read |=> bus_rdata_q[1] == $past(frame_sync && !cas_mf_sync);
    endproperty
    a_cas_flag: assert property (p_cas_flag) else $error("cas search flag");

    property p_crc_flag;
        s_sync_read |=> bus_rdata_q[0]
            == $past(crc_framing_enable && frame_sync && !crc_mf_sync);
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("crc search flag");

    property p_cnt_inc;
        tmr_expire && crc_framing_enable && !crc_mf_sync
            |=> cnt_q == $past(cnt_q) + 6'h01;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("count step");

    property p_cnt_clear;
        crc_mf_sync || !crc_framing_enable |=> cnt_q == 6'h00;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count clear");

    property p_cnt_wrap;
        cnt_q == 6'h3F && tmr_expire |=> cnt_q == 6'h00;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap) else $error("count wrap");

    property p_sig_change;
        signaling_change |=> alm_stk_q[BIT_SA1] && alm_stk_q[BIT_SA0];
    endproperty
    a_sig_change: assert property (p_sig_change) else $error("sig change");

    property p_slip;
        receive_slip |=> alm_stk_q[BIT_SLIP];
    endproperty
    a_slip: assert property (p_slip) else $error("slip latch");

    property p_cl_set;
        rx_bit.valid && !rx_bit.data && !carrier_loss_extended
            && cl_run_q == 12'h0FE |=> cl_q;
    endproperty
    a_cl_set: assert property (p_cl_set) else $error("carrier loss set");

    property p_los_int;
        $changed(frame_sync) |=> !int_n_q ##1 (alm_stk_q[BIT_LOS] || frame_sync);
    endproperty
    a_los_int: assert property (p_los_int) else $error("los interrupt");

    property p_mask_hold;
        s_alarm_write_keep0 |=> $stable(alm_view_q[BIT_LOS]);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask hold");

endmodule

// File: verification/e1rs_line_model.sv
// ==========================================
// Received E1 line stream, one bit every two clocks
module e1rs_line_model (
    input  wire logic                      clk_sys,
    output      e1rs_pkg::e1rs_rx_bit_type rx_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    import e1rs_pkg::*;

    // Frame in bits 11..8, slot in 7..3, bit in 2..0
    logic [11:0] pos = 12'h000;

    initial begin
        rx_bit = '0;
    end

    // Idle data flips so a stale bit never passes for a good one
    task automatic send(input int n, input logic one);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            rx_bit.valid = 1'b1;
            rx_bit.data = one;
            rx_bit.bit_idx = pos[2:0];
            rx_bit.slot = pos[7:3];
            rx_bit.frame = pos[11:8];
            rx_bit.non_align = pos[8];
            @(negedge clk_sys);
            rx_bit.valid = 1'b0;
            rx_bit.data = ~rx_bit.data;
            pos = pos + 12'h001;
        end
    endtask
endmodule

// File: verification/e1rs_status_test.sv
// ==========================================
// Self-checking bench for the receive status block
module e1rs_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    import e1rs_pkg::*;

    localparam int WIN = 20;
    `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

    logic             clk_sys = 1'b0;
    logic             rst_b = 1'b0;
    e1rs_bus_req_type bus_req;
    logic [7:0]       bus_rdata_q;
    e1rs_rx_bit_type  rx_bit;
    logic             frame_sync, cas_mf_sync, crc_mf_sync, crc_framing_enable;
    logic             carrier_loss_extended, signaling_change, receive_slip;
    logic [7:0]       info_events;
    logic             int_n_q;
    int               n_fail = 0;
    int               comparisons = 0;
    int               seed = 30;
    logic [7:0]       rv, ev;
    logic [7:0]       adrs [4] = '{ADDR_ALARM, ADDR_INFO, ADDR_SYNC, 8'h55};

    always #12.5 clk_sys = ~clk_sys;

    e1rs_status #(.SEARCH_WINDOW_CYCLES(WIN)) DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata_q(bus_rdata_q),
        .rx_bit(rx_bit), .frame_sync(frame_sync), .cas_mf_sync(cas_mf_sync),
        .crc_mf_sync(crc_mf_sync), .crc_framing_enable(crc_framing_enable),
        .carrier_loss_extended(carrier_loss_extended), .signaling_change(signaling_change),
        .receive_slip(receive_slip), .info_events(info_events), .int_n_q(int_n_q)
    );

    e1rs_line_model line (
        .clk_sys(clk_sys),
        .rx_bit(rx_bit)
    );

    // ==========================================
    // Host bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req.addr = a;
        bus_req.wdata = d;
        bus_req.wr = 1'b1;
        @(negedge clk_sys);
        bus_req.wr = 1'b0;
        bus_req.wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk_sys);
        bus_req.addr = a;
        bus_req.rd = 1'b1;
        @(negedge clk_sys);
        bus_req.rd = 1'b0;
        rv = bus_rdata_q;
    endtask

    // Double mask write drops stale latches, leaving the live state
    task automatic cur(input logic [7:0] m);
        wr(ADDR_ALARM, m);
        wr(ADDR_ALARM, m);
        rd(ADDR_ALARM);
        rv = rv & m;
    endtask

    task automatic wait_int_low;
        for (int i = 0; i < 6 && int_n_q !== 1'b0; i++) @(negedge clk_sys);
        if (int_n_q !== 1'b0) begin
            n_fail++;
            results();
        end
    endtask

    // ==========================================
    // Reference model
    function automatic logic [7:0] ssr_exp(int cnt, bit fs, bit cas, bit srch);
        logic [5:0] c;
        c = cnt[5:0];
        return {c[5:2], c[0], !fs, fs & !cas, srch};
    endfunction

    // Alarm byte after a long uniform stream of ones or zeros
    function automatic logic [7:0] uni_exp(bit ones);
        logic [7:0] e;
        e = 8'h00;
        e[BIT_SA1] = ones;
        e[BIT_DMA] = ones;
        e[BIT_SA0] = !ones;
        e[BIT_UA1] = ones;
        e[BIT_RA] = ones;
        e[BIT_CL] = !ones;
        return e;
    endfunction

    task automatic results;
        if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail++;
        results();
    end

    // ==========================================
    // Main sequence
    initial begin
        bus_req = '0;
        frame_sync = 1'b1;
        cas_mf_sync = 1'b1;
        crc_mf_sync = 1'b0;
        crc_framing_enable = 1'b0;
        carrier_loss_extended = 1'b0;
        signaling_change = 1'b0;
        receive_slip = 1'b0;
        info_events = 8'h00;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        foreach (adrs[i]) begin
            rd(adrs[i]);
            `CHK(rv, RESET_VIEW)
        end
        wr(ADDR_SYNC, 8'hFF);
        rd(ADDR_SYNC);
        `CHK(rv, 8'h00)
        // Signaling change latches both flags; mask picks what refreshes
        @(negedge clk_sys) signaling_change = 1'b1;
        @(negedge clk_sys) signaling_change = 1'b0;
        wr(ADDR_ALARM, 8'h20);
        rd(ADDR_ALARM);
        `CHK(rv, 8'h20)
        wr(ADDR_ALARM, 8'h80);
        rd(ADDR_ALARM);
        `CHK(rv, 8'hA0)
        @(negedge clk_sys) receive_slip = 1'b1;
        @(negedge clk_sys) receive_slip = 1'b0;
        wr(ADDR_ALARM, 8'h10);
        rd(ADDR_ALARM);
        `CHK(rv, 8'hB0)
        cur(8'h10);
        `CHK(rv, 8'h00)
        ev = $random(seed);
        @(negedge clk_sys) info_events = ev;
        @(negedge clk_sys) info_events = 8'h00;
        wr(ADDR_INFO, 8'hFF);
        rd(ADDR_INFO);
        `CHK(rv, ev)
        // Loss of sync and its interrupt
        @(negedge clk_sys) frame_sync = 1'b0;
        wait_int_low();
        `CHK(int_n_q, 1'b0)
        cur(8'h01);
        `CHK(rv, 8'h01)
        `CHK(int_n_q, 1'b1)
        rd(ADDR_SYNC);
        `CHK(rv, ssr_exp(0, 0, 1, 0))
        @(negedge clk_sys) frame_sync = 1'b1;
        cur(8'h01);
        `CHK(rv, 8'h00)
        // Sync counter steps per window and rolls over
        @(negedge clk_sys);
        crc_framing_enable = 1'b1;
        cas_mf_sync = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (int k = 1; k <= 66; k++) begin
            repeat (18) @(negedge clk_sys);
            rd(ADDR_SYNC);
            `CHK(rv, ssr_exp(k % 64, 1, 0, 1))
        end
        @(negedge clk_sys) crc_mf_sync = 1'b1;
        rd(ADDR_SYNC);
        `CHK(rv, ssr_exp(0, 1, 0, 0))
        @(negedge clk_sys) crc_mf_sync = 1'b0;
        repeat (WIN + 8) @(negedge clk_sys);
        rd(ADDR_SYNC);
        `CHK(rv, ssr_exp(1, 1, 0, 1))
        // Host gives up the search and leaves the mode
        @(negedge clk_sys) crc_framing_enable = 1'b0;
        rd(ADDR_SYNC);
        `CHK(rv, ssr_exp(0, 1, 0, 0))
        // Carrier loss at both thresholds, cleared by ones between
        for (int x = 0; x < 2; x++) begin
            carrier_loss_extended = x[0];
            line.send(600, 1'b1);
            line.send((x == 0) ? 254 : 2047, 1'b0);
            cur(8'h0F);
            `CHK(rv & 8'h02, 8'h00)
            line.send(1, 1'b0);
            wait_int_low();
            `CHK(int_n_q, 1'b0)
            cur(8'h02);
            `CHK(rv, 8'h02)
        end
        // Three multiframes of ones, then of zeros
        line.send(3 * 4096, 1'b1);
        cur(8'hEE);
        `CHK(rv, uni_exp(1))
        line.send(3 * 4096, 1'b0);
        cur(8'hEE);
        `CHK(rv, uni_exp(0))
        results();
    end
endmodule
